// file: core/spw_defs.svh
/*
 * spw_defs.svh: register offsets, field positions and reset values of the
 * serial low-power wake-up block.
 * assumes: included by bare name by the design files.
 */
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH

`define SPW_OFF_CTRL      12'h000
`define SPW_OFF_STAT      12'h004
`define SPW_OFF_MASK      12'h008
`define SPW_OFF_DATA      12'h00c
`define SPW_OFF_TXDATA    12'h010

`define SPW_CTRL_ENABLE   0
`define SPW_CTRL_SLAVE    1
`define SPW_CTRL_SOFTSEL  2
`define SPW_CTRL_LEVEL    3
`define SPW_CTRL_IRQEN    4
`define SPW_CTRL_CPUMASK  5
`define SPW_CTRL_HALT     6
`define SPW_CTRL_WAIT     7

`define SPW_ST_DONE       0
`define SPW_ST_FAULT      1
`define SPW_ST_OVR        2
`define SPW_ST_HALTED     8
`define SPW_ST_HALTST     9
`define SPW_ST_WAKE       10

`define SPW_CTRL_RESET    8'h03
`define SPW_MASK_RESET    3'h0
`define SPW_BITS_PER_BYTE 4'h8

`endif

// file: core/spw_pkg.sv
/*
 * spw_pkg.sv: types shared by the serial low-power wake-up block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package spw_pkg;
    typedef enum logic [2:0] {
        SPW_RUN     = 3'b001,
        SPW_HALTED  = 3'b010,
        SPW_HALTSTT = 3'b100
    } spw_pwr_t;
    typedef logic [7:0] spw_byte_t;
endpackage

// file: core/spw_sync.sv
/*
 * spw_sync.sv: two flip-flop synchroniser for one pin level.
 * assumes: input is asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/100ps
module spw_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);
    logic meta_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= INIT;
            level   <= INIT;
        end else begin
            meta_ff <= pin;
            level   <= meta_ff;
        end
    end
endmodule

// file: core/spw_shift.sv
/*
 * spw_shift.sv: slave shift engine, msb first, mode 0 sampling.
 * assumes: synchronised sclk edges and select from the same clock.
 */
`timescale 1ns/100ps
`include "spw_defs.svh"
module spw_shift (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              run,
    input  wire logic              sel_n,
    input  wire logic              sclk_rise,
    input  wire logic              sclk_fall,
    input  wire logic              mosi,
    input  wire spw_pkg::spw_byte_t tx_byte,
    output spw_pkg::spw_byte_t     rx_byte,
    output logic                   miso_bit,
    output logic                   done
);
    import spw_pkg::*;
    logic [3:0] cnt_ff;
    spw_byte_t  sh_ff;
    // frozen when not running: only done clears, no other state moves
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff  <= 4'h0;
            sh_ff   <= 8'h00;
            rx_byte <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (run) begin
                if (sel_n) begin
                    cnt_ff <= 4'h0;
                    sh_ff  <= tx_byte;
                end else if (sclk_rise) begin
                    sh_ff <= {sh_ff[6:0], mosi};
                    if (cnt_ff == `SPW_BITS_PER_BYTE - 4'h1) begin
                        cnt_ff  <= 4'h0;
                        rx_byte <= {sh_ff[6:0], mosi};
                        done    <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end else if (sclk_fall && cnt_ff == 4'h0 && !done) begin
                    sh_ff <= tx_byte;
                end
            end
        end
    end
    assign miso_bit = sh_ff[7];
endmodule

// file: core/spw_top.sv
/*
 * spw_top.sv: serial slave with wait/halt behaviour, overrun, wake-up and
 * one shared interrupt, registers over apb.
 * assumes: sclk, select and mosi come from an external master on another
 * clock; the chip power controller drives halt/wait in a control register.
 */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "spw_defs.svh"
module spw_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        sel_pin_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe_n,
    input  wire logic        master_fault_in,
    output logic             irq,
    output logic             wake_wait,
    output logic             wake_halt
);
    import spw_pkg::*;

    logic [7:0] ctrl_ff;
    logic [2:0] mask_ff;
    logic       transfer_done_flag;
    logic       master_fault_flag;
    logic       overrun_flag;
    spw_byte_t  serial_data_reg;
    spw_byte_t  tx_ff;
    spw_pwr_t   pwr_ff;
    logic       halt_sel_ok_ff;
    logic       sclk_s;
    logic       sel_s_n;
    logic       mosi_s;
    logic       fault_s;
    logic       sclk_d_ff;
    logic       fault_d_ff;
    logic       miso_bit;
    logic       done;
    spw_byte_t  rx_byte;

    logic wr;
    logic rd;
    logic slave_mode;
    logic soft_select_level;
    logic serial_irq_enable;
    logic cpu_mask;
    logic chip_halt;
    logic eff_sel_n;
    logic run;
    logic fault_ev;
    logic any_flag;
    logic clr_done;
    logic clr_fault;
    logic clr_ovr;

    assign wr                = psel && penable && pwrite;
    assign rd                = psel && penable && !pwrite;
    assign slave_mode        = ctrl_ff[`SPW_CTRL_SLAVE];
    assign soft_select_level = ctrl_ff[`SPW_CTRL_LEVEL];
    assign serial_irq_enable = ctrl_ff[`SPW_CTRL_IRQEN];
    assign cpu_mask          = ctrl_ff[`SPW_CTRL_CPUMASK];
    assign chip_halt         = ctrl_ff[`SPW_CTRL_HALT];
    assign eff_sel_n = ctrl_ff[`SPW_CTRL_SOFTSEL] ? soft_select_level
                                                  : sel_s_n;

    spw_sync #(.INIT(1'b0)) u_sync_sclk (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (sclk),
        .level (sclk_s)
    );
    spw_sync #(.INIT(1'b1)) u_sync_sel (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (sel_pin_n),
        .level (sel_s_n)
    );
    spw_sync #(.INIT(1'b0)) u_sync_mosi (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (mosi),
        .level (mosi_s)
    );
    spw_sync #(.INIT(1'b0)) u_sync_fault (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (master_fault_in),
        .level (fault_s)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d_ff  <= 1'b0;
            fault_d_ff <= 1'b0;
        end else begin
            sclk_d_ff  <= sclk_s;
            fault_d_ff <= fault_s;
        end
    end

    // engine runs in wait; in halt it runs only in slave mode with select low at halt entry
    assign run = ctrl_ff[`SPW_CTRL_ENABLE] && (pwr_ff == SPW_RUN ||
                 (pwr_ff == SPW_HALTSTT && slave_mode) ||
                 (pwr_ff == SPW_HALTED && halt_sel_ok_ff && slave_mode));

    spw_shift u_shift (
        .clk       (clk),
        .nrst      (nrst),
        .run       (run),
        .sel_n     (eff_sel_n || !slave_mode),
        .sclk_rise (sclk_s && !sclk_d_ff),
        .sclk_fall (!sclk_s && sclk_d_ff),
        .mosi      (mosi_s),
        .tx_byte   (tx_ff),
        .rx_byte   (rx_byte),
        .miso_bit  (miso_bit),
        .done      (done)
    );

    assign fault_ev = fault_s && !fault_d_ff && !slave_mode &&
                      ctrl_ff[`SPW_CTRL_ENABLE] && pwr_ff == SPW_RUN;

    // power state: run, halted, halt-state after slave wake
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_ff         <= SPW_RUN;
            halt_sel_ok_ff <= 1'b0;
        end else begin
            case (pwr_ff)
                SPW_RUN: begin
                    if (chip_halt) begin
                        pwr_ff <= SPW_HALTED;
                        halt_sel_ok_ff <= !eff_sel_n;
                    end
                end
                SPW_HALTED: begin
                    if (!chip_halt) begin
                        pwr_ff <= slave_mode ? SPW_HALTSTT : SPW_RUN;
                    end
                end
                SPW_HALTSTT: begin
                    if (!slave_mode || done) begin
                        pwr_ff <= SPW_RUN;
                    end
                end
                default: pwr_ff <= SPW_RUN;
            endcase
        end
    end

    // control register; halt bit cleared by wake-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= `SPW_CTRL_RESET;
        end else begin
            if (wr && paddr == `SPW_OFF_CTRL && pwr_ff != SPW_HALTED) begin
                ctrl_ff <= pwdata[7:0];
            end else if (wr && paddr == `SPW_OFF_CTRL) begin
                ctrl_ff[`SPW_CTRL_HALT] <= pwdata[`SPW_CTRL_HALT];
            end
            if (pwr_ff == SPW_HALTED && done && serial_irq_enable) begin
                ctrl_ff[`SPW_CTRL_HALT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_ff <= `SPW_MASK_RESET;
            tx_ff   <= 8'h00;
        end else if (pwr_ff != SPW_HALTED) begin
            if (wr && paddr == `SPW_OFF_MASK) begin
                mask_ff <= pwdata[2:0];
            end
            if (wr && paddr == `SPW_OFF_TXDATA) begin
                tx_ff <= pwdata[7:0];
            end
        end
    end

    assign clr_done  = wr && paddr == `SPW_OFF_STAT && pwdata[`SPW_ST_DONE];
    assign clr_fault = wr && paddr == `SPW_OFF_STAT && pwdata[`SPW_ST_FAULT];
    assign clr_ovr   = wr && paddr == `SPW_OFF_STAT && pwdata[`SPW_ST_OVR];

    // sticky flags, set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            transfer_done_flag <= 1'b0;
            master_fault_flag  <= 1'b0;
            overrun_flag       <= 1'b0;
            serial_data_reg    <= 8'h00;
        end else begin
            if (clr_done) begin
                transfer_done_flag <= 1'b0;
            end
            if (clr_fault) begin
                master_fault_flag <= 1'b0;
            end
            if (clr_ovr) begin
                overrun_flag <= 1'b0;
            end
            if (done) begin
                transfer_done_flag <= 1'b1;
                // first byte kept for the handler
                if (!transfer_done_flag || clr_done) begin
                    serial_data_reg <= rx_byte;
                end
                if (transfer_done_flag && !clr_done) begin
                    overrun_flag <= 1'b1;
                end
            end
            if (fault_ev) begin
                master_fault_flag <= 1'b1;
            end
        end
    end

    // one gated interrupt for three events
    assign any_flag = (transfer_done_flag && mask_ff[0]) ||
                      (master_fault_flag && mask_ff[1]) ||
                      (overrun_flag && mask_ff[2]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq       <= 1'b0;
            wake_wait <= 1'b0;
            wake_halt <= 1'b0;
            miso      <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            irq       <= any_flag && serial_irq_enable && !cpu_mask;
            wake_wait <= ctrl_ff[`SPW_CTRL_WAIT] && any_flag &&
                         serial_irq_enable;
            wake_halt <= pwr_ff == SPW_HALTED && done && serial_irq_enable;
            miso      <= miso_bit;
            miso_oe_n <= !(slave_mode && !eff_sel_n && run);
        end
    end

    // apb: one wait-free access phase, unmapped reads zero with error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `SPW_OFF_CTRL:   prdata <= {24'h0, ctrl_ff};
                    `SPW_OFF_STAT:   prdata <= {21'h0,
                        pwr_ff == SPW_HALTSTT, pwr_ff == SPW_HALTSTT,
                        pwr_ff == SPW_HALTED, 5'h0, overrun_flag,
                        master_fault_flag, transfer_done_flag};
                    `SPW_OFF_MASK:   prdata <= {29'h0, mask_ff};
                    `SPW_OFF_DATA:   prdata <= {24'h0, serial_data_reg};
                    `SPW_OFF_TXDATA: prdata <= {24'h0, tx_ff};
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end

    a_ovr_double: assert property (@(posedge clk) disable iff (!nrst)
        done && transfer_done_flag && !clr_done |=> overrun_flag)
        else $error("overrun not set on double transfer");
    // irq gated by enable and cpu mask
    a_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
        irq |-> $past(serial_irq_enable) && !$past(cpu_mask))
        else $error("irq raised while gated");
    a_halt_frozen: assert property (@(posedge clk) disable iff (!nrst)
        pwr_ff == SPW_HALTED && !run |=> $stable(serial_data_reg))
        else $error("data changed in halt");
    // no halt wake without select at entry
    a_sel_entry: assert property (@(posedge clk) disable iff (!nrst)
        wake_halt |-> halt_sel_ok_ff)
        else $error("halt wake without select low");
    a_fault_nohalt: assert property (@(posedge clk) disable iff (!nrst)
        pwr_ff == SPW_HALTED && !done |=> !wake_halt)
        else $error("halt ended by other event");
    // leaving slave mode ends halt state
    a_slave_exit: assert property (@(posedge clk) disable iff (!nrst)
        pwr_ff == SPW_HALTSTT && !slave_mode |=> pwr_ff == SPW_RUN)
        else $error("halt state kept after slave exit");
    a_data_kept: assert property (@(posedge clk) disable iff (!nrst)
        done && !transfer_done_flag |=> serial_data_reg == $past(rx_byte))
        else $error("received byte not kept");
    a_wake_state: assert property (@(posedge clk) disable iff (!nrst)
        wake_halt && slave_mode |=> ##[0:2] pwr_ff == SPW_HALTSTT)
        else $error("no resume after wake");
    a_wait_wake: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_ff[`SPW_CTRL_WAIT] && any_flag && serial_irq_enable
        |=> wake_wait)
        else $error("wait not ended by event");
    a_irq_flag: assert property (@(posedge clk) disable iff (!nrst)
        irq |-> $past(any_flag))
        else $error("irq without event flag");
    a_halt_clear: assert property (@(posedge clk) disable iff (!nrst)
        wake_halt |-> !chip_halt)
        else $error("halt kept after wake");
    a_frozen_idle: assert property (@(posedge clk) disable iff (!nrst)
        pwr_ff == SPW_HALTED && !run |=> !done)
        else $error("transfer done while frozen");
endmodule

// file: tb/spw_mstr.sv
/* spw_mstr.sv: behavioural spi master for the slave link, mode 0, msb first.
   assumes: driven by tasks of the bench; link clock runs in frames only. */
`timescale 1ns/100ps
module spw_mstr (
    output logic      sclk,
    output logic      sel_pin_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk      = 1'b0;
        sel_pin_n = 1'b1;
        mosi      = 1'b0;
    end
    task automatic set_sel(input logic lvl);
        sel_pin_n = lvl;
        #200;
    endtask
    // one byte at 125 ns per bit, select left low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        sel_pin_n = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #62.5 sclk = 1'b1;
            rx[i] = miso;
            #62.5 sclk = 1'b0;
        end
        #100 mosi = ~mosi;
    endtask
endmodule

// file: tb/spw_top_test.sv
/* spw_top_test.sv: self-checking bench for the serial wake-up block.
   assumes: spw_mstr on the link, apb master and fault pin driven here. */
`timescale 1ns/100ps
`include "spw_defs.svh"
module spw_top_test;
    import spw_pkg::*;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        master_fault_in;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        sel_pin_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe_n;
    logic        miso_w;
    logic        irq;
    logic        wake_wait;
    logic        wake_halt;
    logic [31:0] rd;
    logic        err;
    spw_byte_t   rx;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_wake = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (wake_halt === 1'b1) n_wake++;
    // released miso line sits at the pull-up level
    assign miso_w = miso_oe_n ? 1'b1 : miso;
    spw_top u_spw_top (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .sel_pin_n(sel_pin_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .master_fault_in(master_fault_in),
        .irq(irq), .wake_wait(wake_wait), .wake_halt(wake_halt));
    spw_mstr u_spw_mstr (.sclk(sclk), .sel_pin_n(sel_pin_n), .mosi(mosi),
        .miso(miso_w));
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            n_fail++;
            results();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic t_reset;
        chk("oe_n", {31'h0, miso_oe_n}, 32'h1);
        rdchk("ctrl", `SPW_OFF_CTRL, 32'h3);
        rdchk("stat", `SPW_OFF_STAT, 32'h0);
        rdchk("mask", `SPW_OFF_MASK, 32'h0);
        rdchk("unmapped", 12'h0f0, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
    endtask
    task automatic t_basic;
        wr(`SPW_OFF_CTRL, 32'h13);
        wr(`SPW_OFF_MASK, 32'h1);
        wr(`SPW_OFF_TXDATA, 32'h3c);
        u_spw_mstr.xfer(8'ha5, rx);
        u_spw_mstr.set_sel(1'b1);
        chk("miso", {24'h0, rx}, 32'h3c);
        rdchk("data", `SPW_OFF_DATA, 32'ha5);
        rdchk("stat", `SPW_OFF_STAT, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(`SPW_OFF_CTRL, 32'h33);
        chk("irq cpu mask", {31'h0, irq}, 32'h0);
        wr(`SPW_OFF_CTRL, 32'h13);
        wr(`SPW_OFF_MASK, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`SPW_OFF_MASK, 32'h1);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`SPW_OFF_STAT, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_ovr;
        wr(`SPW_OFF_MASK, 32'h4);
        u_spw_mstr.xfer(8'h5a, rx);
        u_spw_mstr.xfer(8'h96, rx);
        u_spw_mstr.set_sel(1'b1);
        rdchk("stat ovr", `SPW_OFF_STAT, 32'h5);
        rdchk("data first", `SPW_OFF_DATA, 32'h5a);
        chk("irq ovr", {31'h0, irq}, 32'h1);
        wr(`SPW_OFF_CTRL, 32'h03);
        chk("irq no enable", {31'h0, irq}, 32'h0);
        wr(`SPW_OFF_STAT, 32'h7);
    endtask
    task automatic t_wait;
        wr(`SPW_OFF_MASK, 32'h7);
        wr(`SPW_OFF_CTRL, 32'h93);
        u_spw_mstr.xfer(8'h42, rx);
        u_spw_mstr.set_sel(1'b1);
        chk("wake wait", {31'h0, wake_wait}, 32'h1);
        rdchk("data wait", `SPW_OFF_DATA, 32'h42);
        wr(`SPW_OFF_STAT, 32'h7);
        chk("wake wait clr", {31'h0, wake_wait}, 32'h0);
        wr(`SPW_OFF_CTRL, 32'h91);
        @(posedge clk);
        master_fault_in <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk("stat fault", `SPW_OFF_STAT, 32'h2);
        chk("wake fault", {31'h0, wake_wait}, 32'h1);
        chk("irq fault", {31'h0, irq}, 32'h1);
        master_fault_in <= 1'b0;
        wr(`SPW_OFF_STAT, 32'h7);
        wr(`SPW_OFF_CTRL, 32'h13);
    endtask
    task automatic t_halt(input logic leave_slave);
        int w;
        w = n_wake;
        u_spw_mstr.set_sel(1'b0);
        wr(`SPW_OFF_CTRL, 32'h53);
        rdchk("halted", `SPW_OFF_STAT, 32'h100);
        u_spw_mstr.xfer(8'h81, rx);
        repeat (4) @(posedge clk);
        chk("wake halt", n_wake, w + 1);
        rdchk("data halt", `SPW_OFF_DATA, 32'h81);
        chk("irq woke", {31'h0, irq}, 32'h1);
        apb(1'b0, `SPW_OFF_STAT, 32'h0);
        chk("stat woke", rd & 32'h301, 32'h201);
        wr(`SPW_OFF_STAT, 32'h7);
        if (leave_slave) begin
            wr(`SPW_OFF_CTRL, 32'h11);
        end else begin
            u_spw_mstr.xfer(8'h18, rx);
            repeat (4) @(posedge clk);
            rdchk("data extra", `SPW_OFF_DATA, 32'h18);
        end
        apb(1'b0, `SPW_OFF_STAT, 32'h0);
        chk("normal", rd & 32'h300, 32'h0);
        u_spw_mstr.set_sel(1'b1);
        wr(`SPW_OFF_STAT, 32'h7);
        wr(`SPW_OFF_CTRL, 32'h13);
    endtask
    task automatic t_nosel;
        int w;
        w = n_wake;
        wr(`SPW_OFF_CTRL, 32'h53);
        wr(`SPW_OFF_MASK, 32'h0);
        u_spw_mstr.xfer(8'h99, rx);
        repeat (4) @(posedge clk);
        u_spw_mstr.set_sel(1'b1);
        chk("no wake", n_wake, w);
        rdchk("mask frozen", `SPW_OFF_MASK, 32'h7);
        apb(1'b0, `SPW_OFF_STAT, 32'h0);
        chk("no done", rd & 32'h1, 32'h0);
        wr(`SPW_OFF_CTRL, 32'h13);
        rdchk("ctrl run", `SPW_OFF_CTRL, 32'h13);
    endtask
    task automatic t_softsel;
        int w;
        w = n_wake;
        wr(`SPW_OFF_CTRL, 32'h11);
        rdchk("soft normal", `SPW_OFF_STAT, 32'h0);
        wr(`SPW_OFF_CTRL, 32'h57);
        u_spw_mstr.xfer(8'h66, rx);
        repeat (4) @(posedge clk);
        chk("soft wake", n_wake, w + 1);
        rdchk("soft data", `SPW_OFF_DATA, 32'h66);
        u_spw_mstr.set_sel(1'b1);
        wr(`SPW_OFF_STAT, 32'h7);
        wr(`SPW_OFF_CTRL, 32'h13);
    endtask
    initial begin
        clk = 1'b0;
        nrst <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        master_fault_in <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_basic();
        t_ovr();
        t_wait();
        t_halt(1'b0);
        t_halt(1'b1);
        t_nosel();
        t_softsel();
        results();
    end
endmodule
